// *** aal_cfg.svh ***
// constants for the alarm and result-code block
`ifndef AAL_CFG_SVH
`define AAL_CFG_SVH

`define AAL_RES_W 12
`define AAL_HYST_W 4
`define AAL_CMP_W 14
`define AAL_FRAME_BITS 32
`define AAL_CNT_W 6
`define AAL_IDX_W 5
`define AAL_FLAG_W 8
`define AAL_SEL_W 2
`define AAL_SEL_ALARM 2'h1
`define AAL_CMD_MSB 31
`define AAL_CMD_LSB 24
`define AAL_CMD_READ_ALARM 8'h4a
`define AAL_CODE_MSB 31
`define AAL_CODE_LSB 20
`define AAL_INFLAG_MSB 19
`define AAL_INFLAG_LSB 16
`define AAL_SUPFLAG_MSB 15
`define AAL_SUPFLAG_LSB 12
`define AAL_READ_MSB 7
`define AAL_READ_LSB 0
`define AAL_REF_MV 4096
`define AAL_SUPPLY_HIGH_MV 5300
`define AAL_SUPPLY_LOW_MV 4700

`endif

// *** aal_pkg.sv ***
// types for the alarm and result-code block
`include "aal_cfg.svh"

package aal_pkg;

  typedef logic [`AAL_RES_W-1:0] aal_code_t;

  typedef struct packed {
    logic inHighAct;
    logic inHighTrip;
    logic inLowAct;
    logic inLowTrip;
    logic supHighAct;
    logic supHighTrip;
    logic supLowAct;
    logic supLowTrip;
  } aal_flags_s;

  typedef struct packed {
    logic csMeta;
    logic csSync;
    logic csPrev;
    logic [1:0] supMeta;
    logic [1:0] supSync;
    logic hiState;
    logic loState;
    aal_flags_s flags;
    aal_flags_s snap;
    aal_code_t code;
    logic readPending;
  } aal_core_s;

  typedef struct packed {
    logic [`AAL_CNT_W-1:0] cnt;
  } aal_link_s;

endpackage

// *** aal_alarm_code.sv ***
// result coding, input and supply alarms, and 32-bit serial frame logic
//
// Operation
// - results leave as unsigned straight binary, lowest code at negative full scale.
// - every result is a 12-bit code; step is span over 2**12.
// - step weight follows selected range, 6 mV down to 1.25 mV.
// - alarm pin is an active-high alarm only when function select is 01b.
// - input alarm compares result against programmed high and low limits.
// - supply alarm uses fixed comparator trip points near 5.3 V and 4.7 V.
// - both alarms enabled by default; each has its own disable bit.
// - each source keeps an active flag and a tripped flag, set together.
// - active flag is renewed at each conversion end from the live condition.
// - tripped flag holds until the alarm flags are read, then clears.
// - flags update at conversion end and are readable in any frame.
// - high alarm pin signals over or under limit on supply or input.
// - selected alarm flags may follow the result in the serial word.
// - input high sets above threshold, clears at or below T-H-1.
// - input low sets below threshold, clears at or above T+H+1.
// - separate high and low thresholds share one hysteresis value.
// - bits shift in and out together; the received word and the sent word are separate 32-bit words.
// - frame opens on select low and closes on select high, starting conversion.
`timescale 1ns/1ns

module aal_alarm_code (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic convertStartSelect,
  input wire logic serialIn,
  output logic primarySerialOutput,
  input wire logic [`AAL_RES_W-1:0] resultCode,
  input wire logic conversionDone,
  input wire logic supplyHighCmp,
  input wire logic supplyLowCmp,
  input wire logic [`AAL_SEL_W-1:0] secondaryPinFunctionSelect,
  input wire logic inputAlarmDisable,
  input wire logic supplyAlarmDisable,
  input wire logic [`AAL_RES_W-1:0] highThreshold,
  input wire logic [`AAL_RES_W-1:0] lowThreshold,
  input wire logic [`AAL_HYST_W-1:0] hysteresis,
  input wire logic appendInputFlags,
  input wire logic appendSupplyFlags,
  output logic multiFunctionAlarmPinOut,
  output logic multiFunctionAlarmPinOeN,
  output logic conversionStart,
  output logic [`AAL_FLAG_W-1:0] alarmFlags
);

  // widen a code and add hysteresis plus one, no wrap possible
  function automatic logic [`AAL_CMP_W-1:0] aal_widen_add(
    input logic [`AAL_RES_W-1:0] base,
    input logic [`AAL_HYST_W-1:0] hyst
  );
    logic [`AAL_CMP_W-1:0] sum;
    sum = {2'h0, base} + {{(`AAL_CMP_W-`AAL_HYST_W){1'b0}}, hyst} + `AAL_CMP_W'(1);
    return sum;
  endfunction

  // hysteresis state: set wins, then clear, else hold
  function automatic logic aal_hyst(
    input logic state,
    input logic setCond,
    input logic clrCond
  );
    logic nxt;
    nxt = state;
    if (setCond) begin
      nxt = 1'b1;
    end else if (clrCond) begin
      nxt = 1'b0;
    end
    return nxt;
  endfunction

  aal_pkg::aal_core_s core_reg;
  aal_pkg::aal_core_s core_next;
  aal_pkg::aal_link_s link_reg;
  aal_pkg::aal_link_s link_next;
  logic [`AAL_FRAME_BITS-1:0] rx_reg;
  logic [`AAL_FRAME_BITS-1:0] rx_next;
  logic [`AAL_FRAME_BITS-1:0] txWord;
  logic linkClr;
  logic frameEnd;
  logic readCmd;
  logic setHigh;
  logic clrHigh;
  logic setLow;
  logic clrLow;
  logic newHigh;
  logic newLow;
  logic newSupHigh;
  logic newSupLow;
  logic alarmAny;
  aal_pkg::aal_flags_s fl;

  // select idles high, so the edge detector starts high to avoid a false frame end
  localparam aal_pkg::aal_core_s CORE_RST = '{csMeta: 1'b1, csSync: 1'b1, csPrev: 1'b1,
    default: '0};

  // ---------------- core domain ----------------
  // conversion result kept as delivered: straight binary, no sign change
  always_comb begin
    setHigh = resultCode > highThreshold;
    clrHigh = aal_widen_add(resultCode, hysteresis) <= {2'h0, highThreshold};
    setLow = resultCode < lowThreshold;
    clrLow = {2'h0, resultCode} >= aal_widen_add(lowThreshold, hysteresis);
  end

  always_comb begin
    core_next = core_reg;
    fl = core_reg.flags;
    newHigh = 1'b0;
    newLow = 1'b0;
    newSupHigh = 1'b0;
    newSupLow = 1'b0;
    core_next.csMeta = convertStartSelect;
    core_next.csSync = core_reg.csMeta;
    core_next.csPrev = core_reg.csSync;
    core_next.supMeta = {supplyHighCmp, supplyLowCmp};
    core_next.supSync = core_reg.supMeta;
    // select rising marks the frame end; link clock has stopped by then
    frameEnd = core_reg.csSync & ~core_reg.csPrev;
    readCmd = frameEnd & (rx_reg[`AAL_CMD_MSB:`AAL_CMD_LSB] == `AAL_CMD_READ_ALARM);
    if (conversionDone) begin
      core_next.code = resultCode;
      // input alarm on unsigned codes, shared hysteresis
      if (inputAlarmDisable) begin
        core_next.hiState = 1'b0;
        core_next.loState = 1'b0;
      end else begin
        core_next.hiState = aal_hyst(core_reg.hiState, setHigh, clrHigh);
        core_next.loState = aal_hyst(core_reg.loState, setLow, clrLow);
      end
      newHigh = core_next.hiState;
      newLow = core_next.loState;
      // supply comparators have fixed trip points
      newSupHigh = core_reg.supSync[1] & ~supplyAlarmDisable;
      newSupLow = core_reg.supSync[0] & ~supplyAlarmDisable;
      // active flags are renewed each conversion end
      fl.inHighAct = newHigh;
      fl.inLowAct = newLow;
      fl.supHighAct = newSupHigh;
      fl.supLowAct = newSupLow;
    end
    // tripped flags: a new trip wins over a read in the same cycle
    fl.inHighTrip = (core_reg.flags.inHighTrip & ~readCmd) | newHigh;
    fl.inLowTrip = (core_reg.flags.inLowTrip & ~readCmd) | newLow;
    fl.supHighTrip = (core_reg.flags.supHighTrip & ~readCmd) | newSupHigh;
    fl.supLowTrip = (core_reg.flags.supLowTrip & ~readCmd) | newSupLow;
    core_next.flags = fl;
    if (readCmd) begin
      core_next.snap = core_reg.flags;
    end
    if (frameEnd) begin
      core_next.readPending = readCmd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_reg <= CORE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // output word is held steady between conversion end and frame end
  always_comb begin
    txWord = '0;
    txWord[`AAL_CODE_MSB:`AAL_CODE_LSB] = core_reg.code;
    if (appendInputFlags) begin
      txWord[`AAL_INFLAG_MSB:`AAL_INFLAG_LSB] = {core_reg.flags.inHighAct,
        core_reg.flags.inHighTrip, core_reg.flags.inLowAct, core_reg.flags.inLowTrip};
    end
    if (appendSupplyFlags) begin
      txWord[`AAL_SUPFLAG_MSB:`AAL_SUPFLAG_LSB] = {core_reg.flags.supHighAct,
        core_reg.flags.supHighTrip, core_reg.flags.supLowAct, core_reg.flags.supLowTrip};
    end
    if (core_reg.readPending) begin
      txWord[`AAL_READ_MSB:`AAL_READ_LSB] = core_reg.snap;
    end
  end

  always_comb begin
    alarmAny = core_reg.flags.inHighAct | core_reg.flags.inLowAct |
      core_reg.flags.supHighAct | core_reg.flags.supLowAct;
    multiFunctionAlarmPinOeN = secondaryPinFunctionSelect != `AAL_SEL_ALARM;
    multiFunctionAlarmPinOut = alarmAny & ~multiFunctionAlarmPinOeN;
    conversionStart = frameEnd;
    alarmFlags = core_reg.flags;
  end

  // ---------------- link domain ----------------
  // bit counter is held clear while select is high
  assign linkClr = rst | convertStartSelect;

  always_comb begin
    link_next = link_reg;
    if (link_reg.cnt != `AAL_CNT_W'(`AAL_FRAME_BITS)) begin
      link_next.cnt = link_reg.cnt + `AAL_CNT_W'(1);
    end
    rx_next = {rx_reg[`AAL_FRAME_BITS-2:0], serialIn};
  end

  // capture on rising clock edge, standard mode 0
  always_ff @(posedge sclk or posedge linkClr) begin
    if (linkClr) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // received word survives the frame end so the core can read it
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // msb first; zero after the 32nd bit
  always_comb begin
    if (link_reg.cnt[`AAL_CNT_W-1]) begin
      primarySerialOutput = 1'b0;
    end else begin
      primarySerialOutput = txWord[~link_reg.cnt[`AAL_IDX_W-1:0]];
    end
  end

endmodule // aal_alarm_code

// *** aal_alarm_code_monitor.sv ***
// bound checker for the alarm and code block
`timescale 1ns/1ns
`include "aal_cfg.svh"
module aal_alarm_code_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic convertStartSelect,
  input wire logic [`AAL_RES_W-1:0] resultCode,
  input wire logic conversionDone,
  input wire logic [`AAL_SEL_W-1:0] secondaryPinFunctionSelect,
  input wire logic inputAlarmDisable,
  input wire logic [`AAL_RES_W-1:0] highThreshold,
  input wire logic [`AAL_RES_W-1:0] lowThreshold,
  input wire logic [`AAL_HYST_W-1:0] hysteresis,
  input wire logic multiFunctionAlarmPinOut,
  input wire logic multiFunctionAlarmPinOeN,
  input wire logic conversionStart,
  input wire logic [`AAL_FLAG_W-1:0] alarmFlags
);
  logic inOn;
  assign inOn = conversionDone && !inputAlarmDisable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pin_select: assert property (multiFunctionAlarmPinOeN == (secondaryPinFunctionSelect != 2'h1))
    else $error("pin enable wrong");
  a_pin_or: assert property (multiFunctionAlarmPinOut == (!multiFunctionAlarmPinOeN && |{
    alarmFlags[7], alarmFlags[5], alarmFlags[3], alarmFlags[1]})) else $error("pin level wrong");
  a_high_set: assert property (inOn && resultCode > highThreshold |=> alarmFlags[7:6] == 2'h3)
    else $error("high alarm not set");
  a_high_clear: assert property (inOn && ({2'h0, resultCode} + 14'(hysteresis) + 14'h1 <=
    {2'h0, highThreshold}) |=> !alarmFlags[7]) else $error("high alarm not cleared");
  a_low_set: assert property (inOn && resultCode < lowThreshold |=> alarmFlags[5:4] == 2'h3)
    else $error("low alarm not set");
  a_low_clear: assert property (inOn && ({2'h0, resultCode} >= {2'h0, lowThreshold} +
    14'(hysteresis) + 14'h1) |=> !alarmFlags[5]) else $error("low alarm not cleared");
  a_trip_sticky: assert property ($fell(alarmFlags[6]) |-> $past(conversionStart) ||
    $past(conversionStart, 2) || $past(inputAlarmDisable)) else $error("trip lost");
  a_frame_start: assert property ($rose(convertStartSelect) |-> ##[1:5] conversionStart)
    else $error("no conversion start");
  c_high: cover property (inOn && resultCode > highThreshold);
  c_low: cover property (inOn && resultCode < lowThreshold);
  c_start: cover property (conversionStart);
endmodule // aal_alarm_code_monitor
bind aal_alarm_code aal_alarm_code_monitor mon_u (.clk, .rst, .convertStartSelect, .resultCode,
  .conversionDone, .secondaryPinFunctionSelect, .inputAlarmDisable, .highThreshold, .lowThreshold,
  .hysteresis, .multiFunctionAlarmPinOut, .multiFunctionAlarmPinOeN, .conversionStart, .alarmFlags);

// *** aal_spi_host.sv ***
// host serial port model, mode 0, clock only inside frames
`timescale 1ns/1ns
module aal_spi_host (
  input wire logic sdo,
  output logic sclk,
  output logic selN,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    mosi = 1'b0;
  end
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    selN <= 1'b0;
    mosi <= tx[31];
    #6;
    for (int i = 31; i >= 0; i--) begin
      sclk <= 1'b1;
      rx[i] = sdo;
      #6;
      sclk <= 1'b0;
      if (i > 0) mosi <= tx[i-1];
      #6;
    end
    selN <= 1'b1;
    mosi <= ~mosi;
  endtask
endmodule // aal_spi_host

// *** test_adc_alarm_and_code_logic.sv ***
// self-checking bench for the alarm and code block
`timescale 1ns/1ns
`include "aal_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module test_adc_alarm_and_code_logic;
  logic clk = 1'b0, done = 1'b0, supHi = 1'b0, supLo = 1'b0, inDis = 1'b0, supDis = 1'b0;
  logic rst;
  logic sclk, selN, mosi, sdo, pinOut, pinOeN, convStart;
  logic [11:0] code = 12'h0;
  logic [1:0] sel = 2'h1;
  logic [7:0] flags;
  logic [31:0] rx;
  int error_cnt = 0, checked = 0;
  always #50 clk = ~clk;
  aal_spi_host host_u (.sdo(sdo), .sclk(sclk), .selN(selN), .mosi(mosi));
  aal_alarm_code dut_u (.clk(clk), .rst(rst), .sclk(sclk), .convertStartSelect(selN),
    .serialIn(mosi), .primarySerialOutput(sdo), .resultCode(code), .conversionDone(done),
    .supplyHighCmp(supHi), .supplyLowCmp(supLo), .secondaryPinFunctionSelect(sel),
    .inputAlarmDisable(inDis), .supplyAlarmDisable(supDis), .highThreshold(12'h800),
    .lowThreshold(12'h100), .hysteresis(4'h3), .appendInputFlags(1'b1),
    .appendSupplyFlags(1'b0), .multiFunctionAlarmPinOut(pinOut),
    .multiFunctionAlarmPinOeN(pinOeN), .conversionStart(convStart), .alarmFlags(flags));
  task automatic conv(input logic [11:0] c, input logic [7:0] exp);
    @(posedge clk) code <= c;
    done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    @(negedge clk) `CHK(flags, exp)
  endtask
  task automatic t_hyst;
    conv(12'h801, 8'hc0);
    `CHK(pinOut, 1'b1)
    conv(12'h7fd, 8'hc0);
    conv(12'h7fc, 8'h40);
    `CHK(pinOut, 1'b0)
    conv(12'h0ff, 8'h70);
    conv(12'h103, 8'h70);
    conv(12'h104, 8'h50);
    $display("t_hyst done");
  endtask
  task automatic t_frame;
    host_u.frame(32'h4a000000, rx);
    `CHK(rx, 32'h10450000)
    repeat (8) @(posedge clk);
    `CHK(flags, 8'h00)
    host_u.frame(32'h0, rx);
    `CHK(rx, 32'h10400050)
    repeat (8) @(posedge clk);
    $display("t_frame done");
  endtask
  task automatic t_supply;
    @(posedge clk) supHi <= 1'b1;
    supLo <= 1'b1;
    repeat (4) @(posedge clk);
    conv(12'h400, 8'h0f);
    `CHK(pinOut, 1'b1)
    @(posedge clk) supDis <= 1'b1;
    inDis <= 1'b1;
    conv(12'hfff, 8'h05);
    @(posedge clk) sel <= 2'h2;
    @(negedge clk) `CHK({pinOeN, pinOut}, 2'h2)
    $display("t_supply done");
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_hyst();
    t_frame();
    t_supply();
    tally_and_finish();
  end
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // test_adc_alarm_and_code_logic
